// File: hw/ams_apb_slave.v
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// APB slave front end: zero wait states, error on unmapped addresses.
// ----------------------------------------------------------------------
module ams_apb_slave (
    input wire clk_i,
    input wire rst_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] rdata_i,
    input wire hit_i,
    output wire wr_o,
    output wire rd_o,
    output reg [31:0] prdata_o,
    output reg pslverr_o
);
    // Access phase strobes; the slave always answers in the access cycle.
    assign wr_o = psel_i && penable_i && pwrite_i && hit_i;
    assign rd_o = psel_i && penable_i && !pwrite_i;

    // Read data and error are captured in the setup cycle.
    always @(posedge clk_i) begin
        if (rst_i) begin
            prdata_o <= 32'h0000_0000;
            pslverr_o <= 1'b0;
        end else if (psel_i && !penable_i) begin
            prdata_o <= pwrite_i ? 32'h0000_0000 : rdata_i;
            pslverr_o <= !hit_i;
        end
    end
endmodule // ams_apb_slave

// File: hw/ams_baud_gen.v
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Baud generator: counts down from the reload value, pulses at zero.
// ----------------------------------------------------------------------
module ams_baud_gen #(
    parameter W = 16
) (
    input wire clk_i,
    input wire rst_i,
    input wire run_i,
    input wire load_i,
    input wire [W-1:0] reload_i,
    output reg tick_o
);
    reg [W-1:0] cnt_reg;

    // Reload on request, count while running, flag the rollover.
    always @(posedge clk_i) begin
        if (rst_i || !run_i || load_i) begin
            cnt_reg <= reload_i;
            tick_o <= 1'b0;
        end else if (cnt_reg == {W{1'b0}}) begin
            cnt_reg <= reload_i;
            tick_o <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg - {{(W-1){1'b0}}, 1'b1};
            tick_o <= 1'b0;
        end
    end
endmodule // ams_baud_gen

// File: hw/ams_regs.vh
`ifndef AMS_REGS_VH
`define AMS_REGS_VH
// ----------------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------------
`define AMS_CTRL_ADDR 12'h000
`define AMS_BAUD_ADDR 12'h004
`define AMS_STAT_ADDR 12'h008
`define AMS_MASK_ADDR 12'h00c
`define AMS_BUF_ADDR 12'h010
`define AMS_LINE_ADDR 12'h014
// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define AMS_CTRL_ACK_EN 0
`define AMS_CTRL_ACK_DATA 1
`define AMS_CTRL_STOP_EN 2
`define AMS_CTRL_HOLD 3
`define AMS_ST_IRQ 0
`define AMS_ST_WRITE_COLLISION_FLAG 1
`define AMS_ST_STOP 2
`define AMS_ST_ACKDONE 3
`define AMS_ST_W 4
// ----------------------------------------------------------------------
// Reset values and timing counts
// ----------------------------------------------------------------------
`define AMS_BAUD_RST 16'h0009
`define AMS_BAUD_W 16
`endif

// File: hw/ams_seq.v
// Added by the designer: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`include "ams_regs.vh"
// Functional notes
// - Setting the acknowledge enable pulls SCL low and puts the ack data bit on SDA.
// - Ack sequence waits one baud period, then releases SCL.
// - After SCL is seen high, wait one more period, then pull SCL low.
// - Then clear the acknowledge enable, stop the baud generator, go idle.
// - Buffer write during an ack sequence sets write collision, buffer kept.
// - After each byte, SCL stays held low after the ninth falling edge.
// - Setting the stop enable pulls SDA low.
// - Once SDA is seen low, reload the baud generator and count to zero.
// - On expiry release SCL; one period later release SDA.
// - SDA high while SCL high sets the stop-detected bit.
// - One period after stop detect, clear stop enable and set port irq flag.
// - Buffer write during a stop sequence sets write collision and is discarded.
module ams_seq (
    // Clock and reset
    input wire CLK_SYS_I,
    input wire SYS_RST_I,
    // APB
    input wire PSEL_I,
    input wire PENABLE_I,
    input wire PWRITE_I,
    input wire [11:0] PADDR_I,
    input wire [31:0] PWDATA_I,
    output wire [31:0] PRDATA_O,
    output reg PREADY_O,
    output wire PSLVERR_O,
    // Two-wire bus, open drain: enable low means pulling low
    input wire SCL_I,
    output reg SCL_O,
    output reg SCL_OE_N_O,
    input wire SDA_I,
    output reg SDA_O,
    output reg SDA_OE_N_O,
    // Byte engine hand-off
    input wire BYTE_DONE_I,
    // Interrupt
    output reg IRQ_O
);
    // ------------------------------------------------------------------
    // State codes
    // ------------------------------------------------------------------
    localparam [3:0] S_IDLE = 4'h0;
    localparam [3:0] S_ACK_LOW = 4'h1;
    localparam [3:0] S_ACK_WAIT_HI = 4'h2;
    localparam [3:0] S_ACK_HIGH = 4'h3;
    localparam [3:0] S_STOP_SDA = 4'h4;
    localparam [3:0] S_STOP_CNT = 4'h5;
    localparam [3:0] S_STOP_SCL = 4'h6;
    localparam [3:0] S_STOP_DET = 4'h7;
    localparam [3:0] S_STOP_END = 4'h8;

    reg [3:0] state_reg;
    reg [3:0] state_next;
    reg ack_seq_enable_reg;
    reg ack_data_value_reg;
    reg stop_seq_enable_reg;
    reg hold_low_reg;
    reg [`AMS_BAUD_W-1:0] baud_reload_reg;
    reg [`AMS_ST_W-1:0] stat_reg;
    reg [`AMS_ST_W-1:0] mask_reg;
    reg [7:0] serial_shift_buffer_reg;
    reg scl_low_next;
    reg sda_low_next;
    reg brg_run;
    reg brg_load;
    reg [31:0] rdata;
    reg hit;
    wire tick;
    wire wr;
    wire wr_ctrl;
    wire wr_baud;
    wire wr_stat;
    wire wr_mask;
    wire wr_buf;
    wire wr_buf_ok;
    wire busy;
    wire [`AMS_ST_W-1:0] ev;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Address match used in several decodes.
    function is_addr;
        input [11:0] a;
        input [11:0] b;
        begin
            is_addr = (a == b);
        end
    endfunction

    // A sequence counts as running from the enable write until its own clear.
    assign busy = (state_reg != S_IDLE) || ack_seq_enable_reg || stop_seq_enable_reg;

    // ------------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------------
    // Address decode and read mux.
    always @* begin
        hit = 1'b1;
        rdata = 32'h0000_0000;
        case (PADDR_I)
            `AMS_CTRL_ADDR: rdata = {28'h0000000, hold_low_reg, stop_seq_enable_reg,
                                     ack_data_value_reg, ack_seq_enable_reg};
            `AMS_BAUD_ADDR: rdata = {16'h0000, baud_reload_reg};
            `AMS_STAT_ADDR: rdata = {28'h0000000, stat_reg};
            `AMS_MASK_ADDR: rdata = {28'h0000000, mask_reg};
            `AMS_BUF_ADDR: rdata = {24'h000000, serial_shift_buffer_reg};
            `AMS_LINE_ADDR: rdata = {26'h0, state_reg, SDA_I, SCL_I};
            default: hit = 1'b0;
        endcase
    end

    ams_apb_slave u_apb (
        .clk_i(CLK_SYS_I),
        .rst_i(SYS_RST_I),
        .psel_i(PSEL_I),
        .penable_i(PENABLE_I),
        .pwrite_i(PWRITE_I),
        .paddr_i(PADDR_I),
        .rdata_i(rdata),
        .hit_i(hit),
        .wr_o(wr),
        .rd_o(),
        .prdata_o(PRDATA_O),
        .pslverr_o(PSLVERR_O)
    );

    // ------------------------------------------------------------------
    // Write strobes
    // ------------------------------------------------------------------
    // One strobe per writable register (all but the line register), taken in the access cycle of a mapped write.
    assign wr_ctrl = wr && is_addr(PADDR_I, `AMS_CTRL_ADDR);
    assign wr_baud = wr && is_addr(PADDR_I, `AMS_BAUD_ADDR);
    assign wr_stat = wr && is_addr(PADDR_I, `AMS_STAT_ADDR);
    assign wr_mask = wr && is_addr(PADDR_I, `AMS_MASK_ADDR);
    assign wr_buf = wr && is_addr(PADDR_I, `AMS_BUF_ADDR);
    // A buffer write is refused while any sequence is pending or running.
    assign wr_buf_ok = wr_buf && !busy;

    // ------------------------------------------------------------------
    // Baud generator
    // ------------------------------------------------------------------
    // Generator runs only while a sequence is active.
    // It is reloaded whenever a phase waits on a pin, so each count starts fresh.
    ams_baud_gen #(
        .W(`AMS_BAUD_W)
    ) u_brg (
        .clk_i(CLK_SYS_I),
        .rst_i(SYS_RST_I),
        .run_i(brg_run),
        .load_i(brg_load),
        .reload_i(baud_reload_reg),
        .tick_o(tick)
    );

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    // Next state, line drives and generator control.
    // The tick and the pins are both registered, so a pin change lands two
    // clocks after the generator reaches zero.
    always @* begin
        state_next = state_reg;
        scl_low_next = hold_low_reg;
        sda_low_next = 1'b0;
        brg_run = 1'b0;
        brg_load = 1'b0;
        case (state_reg)
            S_IDLE: begin
                if (ack_seq_enable_reg) begin
                    state_next = S_ACK_LOW;
                    scl_low_next = 1'b1;
                    sda_low_next = !ack_data_value_reg;
                end else if (stop_seq_enable_reg) begin
                    state_next = S_STOP_SDA;
                    scl_low_next = 1'b1;
                    sda_low_next = 1'b1;
                end
            end
            S_ACK_LOW: begin
                brg_run = 1'b1;
                scl_low_next = 1'b1;
                sda_low_next = !ack_data_value_reg;
                if (tick) begin
                    state_next = S_ACK_WAIT_HI;
                    scl_low_next = 1'b0;
                end
            end
            S_ACK_WAIT_HI: begin
                scl_low_next = 1'b0;
                sda_low_next = !ack_data_value_reg;
                brg_load = 1'b1;
                brg_run = 1'b1;
                if (SCL_I) begin
                    state_next = S_ACK_HIGH;
                end
            end
            S_ACK_HIGH: begin
                brg_run = 1'b1;
                scl_low_next = 1'b0;
                sda_low_next = !ack_data_value_reg;
                if (tick) begin
                    state_next = S_IDLE;
                    scl_low_next = 1'b1;
                end
            end
            S_STOP_SDA: begin
                scl_low_next = 1'b1;
                sda_low_next = 1'b1;
                brg_load = 1'b1;
                brg_run = 1'b1;
                if (!SDA_I) begin
                    state_next = S_STOP_CNT;
                end
            end
            S_STOP_CNT: begin
                brg_run = 1'b1;
                scl_low_next = 1'b1;
                sda_low_next = 1'b1;
                if (tick) begin
                    state_next = S_STOP_SCL;
                    scl_low_next = 1'b0;
                end
            end
            S_STOP_SCL: begin
                brg_run = 1'b1;
                scl_low_next = 1'b0;
                sda_low_next = 1'b1;
                if (tick) begin
                    state_next = S_STOP_DET;
                    sda_low_next = 1'b0;
                end
            end
            S_STOP_DET: begin
                scl_low_next = 1'b0;
                brg_load = 1'b1;
                brg_run = 1'b1;
                if (SDA_I && SCL_I) begin
                    state_next = S_STOP_END;
                end
            end
            S_STOP_END: begin
                brg_run = 1'b1;
                scl_low_next = 1'b0;
                if (tick) begin
                    state_next = S_IDLE;
                end
            end
            default: begin
                state_next = S_IDLE;
            end
        endcase
    end

    // Events raised this cycle, each a one-cycle pulse.
    // Write collision covers both sequences, so one flag serves ack and stop.
    assign ev[`AMS_ST_IRQ] = (state_reg == S_STOP_END) && tick;
    assign ev[`AMS_ST_WRITE_COLLISION_FLAG] = wr_buf && busy;
    assign ev[`AMS_ST_STOP] = (state_reg == S_STOP_DET) && SDA_I && SCL_I;
    assign ev[`AMS_ST_ACKDONE] = (state_reg == S_ACK_HIGH) && tick;

    // ------------------------------------------------------------------
    // Registers and pins
    // ------------------------------------------------------------------
    // Control bits: software sets, hardware clears the enables at sequence end; hold is set by byte done and ack end, cleared at stop end.
    // A control write wins over the hardware clears; software must not write mid-sequence.
    always @(posedge CLK_SYS_I) begin
        if (SYS_RST_I) begin
            state_reg <= S_IDLE;
            ack_seq_enable_reg <= 1'b0;
            ack_data_value_reg <= 1'b0;
            stop_seq_enable_reg <= 1'b0;
            hold_low_reg <= 1'b0;
            baud_reload_reg <= `AMS_BAUD_RST;
            mask_reg <= {`AMS_ST_W{1'b0}};
            serial_shift_buffer_reg <= 8'h00;
        end else begin
            state_reg <= state_next;
            if (wr_ctrl) begin
                ack_seq_enable_reg <= PWDATA_I[`AMS_CTRL_ACK_EN];
                ack_data_value_reg <= PWDATA_I[`AMS_CTRL_ACK_DATA];
                stop_seq_enable_reg <= PWDATA_I[`AMS_CTRL_STOP_EN];
                hold_low_reg <= PWDATA_I[`AMS_CTRL_HOLD];
            end else begin
                if (ev[`AMS_ST_ACKDONE]) begin
                    ack_seq_enable_reg <= 1'b0;
                end
                if (ev[`AMS_ST_IRQ]) begin
                    stop_seq_enable_reg <= 1'b0;
                end
                if (BYTE_DONE_I) begin
                    hold_low_reg <= 1'b1;
                end else if (ev[`AMS_ST_ACKDONE] || ev[`AMS_ST_IRQ]) begin
                    hold_low_reg <= ev[`AMS_ST_ACKDONE];
                end
            end
            if (wr_baud) begin
                baud_reload_reg <= PWDATA_I[`AMS_BAUD_W-1:0];
            end
            if (wr_mask) begin
                mask_reg <= PWDATA_I[`AMS_ST_W-1:0];
            end
            if (wr_buf_ok) begin
                serial_shift_buffer_reg <= PWDATA_I[7:0];
            end
        end
    end

    // Sticky status: a new event wins over a write-one clear.
    always @(posedge CLK_SYS_I) begin
        if (SYS_RST_I) begin
            stat_reg <= {`AMS_ST_W{1'b0}};
        end else if (wr_stat) begin
            stat_reg <= (stat_reg & ~PWDATA_I[`AMS_ST_W-1:0]) | ev;
        end else begin
            stat_reg <= stat_reg | ev;
        end
    end

    // Registered pin drives and interrupt level.
    // Enable low means the pin is pulled low; the data output mirrors the enable.
    always @(posedge CLK_SYS_I) begin
        if (SYS_RST_I) begin
            SCL_O <= 1'b1;
            SCL_OE_N_O <= 1'b1;
            SDA_O <= 1'b1;
            SDA_OE_N_O <= 1'b1;
            IRQ_O <= 1'b0;
            PREADY_O <= 1'b0;
        end else begin
            SCL_O <= !scl_low_next;
            SCL_OE_N_O <= !scl_low_next;
            SDA_O <= !sda_low_next;
            SDA_OE_N_O <= !sda_low_next;
            IRQ_O <= |((stat_reg | ev) & mask_reg);
            PREADY_O <= 1'b1;
        end
    end
endmodule // ams_seq

// File: tb/ams_bus_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Target side of the two-wire bus: pull-ups and clock stretching.
// ----------------------------------------------------------------------
module ams_bus_model (
    // Clock
    input wire clk_i,
    // Controller drivers, low enable means pulling low
    input wire scl_oe_n_i,
    input wire sda_oe_n_i,
    // Cycles the target keeps SCL low after a release
    input wire [7:0] stretch_i,
    // Resolved wire levels
    output wire scl_o,
    output wire sda_o
);
    reg [7:0] cnt_reg = 8'h00;
    reg oe_q = 1'b1;

    // A release of SCL starts the stretch count so the wire stays low.
    always @(posedge clk_i) begin
        oe_q <= scl_oe_n_i;
        if (scl_oe_n_i && !oe_q && stretch_i != 8'h00) begin
            cnt_reg <= stretch_i - 8'h01;
        end else if (cnt_reg != 8'h00) begin
            cnt_reg <= cnt_reg - 8'h01;
        end
    end

    // Released lines float to the pull-up level.
    assign scl_o = scl_oe_n_i && cnt_reg == 8'h00 && (oe_q || stretch_i == 8'h00);
    assign sda_o = sda_oe_n_i;
endmodule // ams_bus_model

// File: tb/ams_seq_sva.sv
`timescale 1ns/1ps
`include "ams_regs.vh"
// ----------------------------------------------------------------------
// Port checker for the acknowledge and stop sequencer.
// ----------------------------------------------------------------------
module ams_seq_sva (
    // Clock and reset
    input wire CLK_SYS_I,
    input wire SYS_RST_I,
    // APB
    input wire PSEL_I,
    input wire PENABLE_I,
    input wire PWRITE_I,
    input wire [11:0] PADDR_I,
    input wire [31:0] PWDATA_I,
    input wire PSLVERR_O,
    // Two-wire bus and byte engine
    input wire SCL_I,
    input wire SCL_OE_N_O,
    input wire SDA_OE_N_O,
    input wire BYTE_DONE_I
);
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (SYS_RST_I);
    reg bdef;
    wire wr_acc = PSEL_I && PENABLE_I && PWRITE_I;
    wire ackw = wr_acc && PADDR_I == `AMS_CTRL_ADDR && PWDATA_I[0];
    wire stopw = wr_acc && PADDR_I == `AMS_CTRL_ADDR && !PWDATA_I[0] && PWDATA_I[2];

    // Tracks whether the baud reload holds its default, which the timed checks assume.
    always @(posedge CLK_SYS_I) begin
        if (SYS_RST_I) begin
            bdef <= 1'b1;
        end else if (wr_acc && PADDR_I == `AMS_BAUD_ADDR) begin
            bdef <= PWDATA_I[15:0] == `AMS_BAUD_RST;
        end
    end

    property p_slverr;
        PSEL_I && PENABLE_I |->
            PSLVERR_O == (PADDR_I > `AMS_LINE_ADDR || PADDR_I[1:0] != 2'b00);
    endproperty
    a_slverr: assert property (p_slverr) else $error("error response mismatch");
    property p_ack_start;
        ackw |=> ##1 (!SCL_OE_N_O && SDA_OE_N_O == $past(PWDATA_I[1], 2));
    endproperty
    a_ack_start: assert property (p_ack_start) else $error("ack start wrong");
    property p_ack_low;
        ackw && bdef |=> ##1 !SCL_OE_N_O [*8] ##1 !SCL_OE_N_O [*3] ##1 SCL_OE_N_O;
    endproperty
    a_ack_low: assert property (p_ack_low) else $error("ack low time wrong");
    property p_stretch;
        SCL_OE_N_O && !SCL_I |=> SCL_OE_N_O;
    endproperty
    a_stretch: assert property (p_stretch) else $error("clock pulled during stretch");
    property p_byte_hold;
        BYTE_DONE_I |-> ##[1:2] !SCL_OE_N_O ##1 !SCL_OE_N_O;
    endproperty
    a_byte_hold: assert property (p_byte_hold) else $error("clock not held");
    property p_stop_start;
        stopw |=> ##1 !SDA_OE_N_O;
    endproperty
    a_stop_start: assert property (p_stop_start) else $error("stop start wrong");
    property p_stop_seq;
        stopw && bdef |=> ##1 (!SDA_OE_N_O && !SCL_OE_N_O) [*8]
            ##1 (!SDA_OE_N_O && !SCL_OE_N_O) [*4] ##1 SCL_OE_N_O;
    endproperty
    a_stop_seq: assert property (p_stop_seq) else $error("stop timing wrong");
    property p_stop_order;
        $rose(SDA_OE_N_O) && SCL_OE_N_O |-> SCL_I && $past(SCL_OE_N_O, 3);
    endproperty
    a_stop_order: assert property (p_stop_order) else $error("data freed early");
endmodule // ams_seq_sva

bind ams_seq ams_seq_sva u_sva (.CLK_SYS_I(CLK_SYS_I), .SYS_RST_I(SYS_RST_I),
    .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
    .PWDATA_I(PWDATA_I), .PSLVERR_O(PSLVERR_O), .SCL_I(SCL_I), .SCL_OE_N_O(SCL_OE_N_O),
    .SDA_OE_N_O(SDA_OE_N_O), .BYTE_DONE_I(BYTE_DONE_I));

// File: tb/ams_seq_tb.sv
`timescale 1ns/1ps
`include "ams_regs.vh"
// ----------------------------------------------------------------------
// Register level bench for the acknowledge and stop sequencer.
// ----------------------------------------------------------------------
module ams_seq_tb;
    reg clk = 1'b0;
    reg rst = 1'b1;
    reg psel = 1'b0;
    reg stop_seq_enable = 1'b0;
    reg pwr = 1'b0;
    reg [11:0] paddr = 12'h000;
    reg [31:0] pwdata = 32'h0;
    reg byte_done = 1'b0;
    reg [7:0] stretch = 8'h00;
    reg [31:0] rdat;
    reg serr;
    wire scl, sda, scl_o, sda_o, scl_oe_n, sda_oe_n, irq, pready, pslverr;
    wire [31:0] prdata;
    integer num_errors = 0;
    integer compares = 0;
    integer i, g, b;

    // System clock at 40 MHz.
    always #12.5 clk = ~clk;

    ams_bus_model u_bus (.clk_i(clk), .scl_oe_n_i(scl_oe_n), .sda_oe_n_i(sda_oe_n),
        .stretch_i(stretch), .scl_o(scl), .sda_o(sda));
    ams_seq DUT (.CLK_SYS_I(clk), .SYS_RST_I(rst), .PSEL_I(psel), .PENABLE_I(stop_seq_enable),
        .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .SCL_I(scl), .SCL_O(scl_o),
        .SCL_OE_N_O(scl_oe_n), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE_N_O(sda_oe_n),
        .BYTE_DONE_I(byte_done), .IRQ_O(irq));

    // Prints the counts and the verdict, then ends the run.
    task test_done;
        begin
            $display("errors %0d compares %0d", num_errors, compares);
            if (num_errors == 0 && compares > 0) begin
                $display("All tests passed");
            end else begin
                $display("Some tests failed");
            end
            $finish;
        end
    endtask

    // Compares one result against its expected value.
    task chk(input [31:0] got, input [31:0] exp);
        begin
            compares = compares + 1;
            if (got !== exp) begin
                num_errors = num_errors + 1;
                $display("BAD %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask

    // One APB transfer; the request holds until pready is seen high.
    task apb(input w, input [11:0] a, input [31:0] d);
        integer n;
        begin
            @(posedge clk);
            psel <= 1'b1;
            pwr <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge clk);
            stop_seq_enable <= 1'b1;
            n = 0;
            @(posedge clk);
            while (pready !== 1'b1) begin
                n = n + 1;
                if (n > 50) begin
                    num_errors = num_errors + 1;
                    test_done;
                end
                @(posedge clk);
            end
            rdat = prdata;
            serr = pslverr;
            psel <= 1'b0;
            stop_seq_enable <= 1'b0;
        end
    endtask

    // Reads a register until the masked bits match, within a bound.
    task poll(input [11:0] a, input [31:0] m, input [31:0] v);
        integer n;
        begin
            n = 0;
            apb(1'b0, a, 32'h0);
            while ((rdat & m) !== v) begin
                n = n + 1;
                if (n > 200) begin
                    num_errors = num_errors + 1;
                    test_done;
                end
                apb(1'b0, a, 32'h0);
            end
        end
    endtask

    // Counts cycles from the clock release to the data release.
    task gap(output integer cnt);
        integer n;
        begin
            n = 0;
            cnt = 0;
            while (scl_oe_n !== 1'b1 && n < 300) begin
                @(posedge clk);
                n = n + 1;
            end
            while (sda_oe_n !== 1'b1 && n < 300) begin
                @(posedge clk);
                n = n + 1;
                cnt = cnt + 1;
            end
            if (n >= 300) begin
                num_errors = num_errors + 1;
                test_done;
            end
        end
    endtask

    // Ends the byte so the clock is held low.
    task byte_end;
        begin
            @(posedge clk);
            byte_done <= 1'b1;
            @(posedge clk);
            byte_done <= 1'b0;
            repeat (3) @(posedge clk);
        end
    endtask

    // Main sequence: reset, register defaults, acknowledge, then stop.
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        apb(1'b0, `AMS_BAUD_ADDR, 32'h0);
        chk(rdat, 32'h9);
        apb(1'b0, 12'h040, 32'h0);
        chk({rdat[30:0], serr}, 32'h1);
        apb(1'b1, `AMS_MASK_ADDR, 32'hf);
        stretch <= 8'h06;
        for (i = 0; i < 2; i = i + 1) begin
            apb(1'b1, `AMS_BUF_ADDR, 32'h5a);
            byte_end;
            chk(scl_oe_n, 32'h0);
            apb(1'b1, `AMS_CTRL_ADDR, {30'h0, i[0], 1'b1});
            repeat (2) @(posedge clk);
            chk({scl_oe_n, sda_oe_n}, {31'h0, i[0]});
            chk({scl_o, sda_o}, {31'h0, i[0]});
            apb(1'b1, `AMS_BUF_ADDR, 32'ha5);
            poll(`AMS_CTRL_ADDR, 32'h1, 32'h0);
            apb(1'b0, `AMS_STAT_ADDR, 32'h0);
            chk(rdat[3:0], 32'ha);
            chk(irq, 32'h1);
            apb(1'b0, `AMS_BUF_ADDR, 32'h0);
            chk(rdat[7:0], 32'h5a);
            apb(1'b1, `AMS_STAT_ADDR, 32'hf);
            repeat (2) @(posedge clk);
            chk(irq, 32'h0);
        end
        stretch <= 8'h00;
        for (i = 0; i < 2; i = i + 1) begin
            b = (i == 0) ? 9 : 3;
            apb(1'b1, `AMS_MASK_ADDR, 32'h0);
            apb(1'b1, `AMS_BAUD_ADDR, b);
            byte_end;
            apb(1'b1, `AMS_CTRL_ADDR, 32'h4);
            repeat (2) @(posedge clk);
            chk(sda_oe_n, 32'h0);
            apb(1'b1, `AMS_BUF_ADDR, 32'h11);
            gap(g);
            chk(g, b + 1);
            poll(`AMS_CTRL_ADDR, 32'h4, 32'h0);
            apb(1'b0, `AMS_STAT_ADDR, 32'h0);
            chk(rdat[2:0], 32'h7);
            chk(irq, 32'h0);
            apb(1'b1, `AMS_MASK_ADDR, 32'h1);
            repeat (2) @(posedge clk);
            chk(irq, 32'h1);
            apb(1'b0, `AMS_BUF_ADDR, 32'h0);
            chk(rdat[7:0], 32'h5a);
            apb(1'b1, `AMS_STAT_ADDR, 32'h7);
            repeat (2) @(posedge clk);
            chk(irq, 32'h0);
        end
        test_done;
    end
endmodule // ams_seq_tb
